//--- hw/lixe_pkg.sv
`default_nettype none
package lixe_pkg;
	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [3:0] LIXE_NIB_IMM = 4'hc;
	localparam logic [3:0] LIXE_NIB_R2W = 4'h8;
	localparam logic [3:0] LIXE_NIB_W2R = 4'h9;
	localparam logic [7:0] LIXE_OP_LDIR = 8'hc7;
	localparam logic [7:0] LIXE_OP_STIR = 8'hd7;
	localparam logic [7:0] LIXE_OP_RR = 8'he4;
	localparam logic [7:0] LIXE_OP_RIR = 8'he5;
	localparam logic [7:0] LIXE_OP_RIM = 8'he6;
	localparam logic [7:0] LIXE_OP_IRIM = 8'hd6;
	localparam logic [7:0] LIXE_OP_IRR = 8'hf5;
	localparam logic [7:0] LIXE_OP_LDX = 8'h87;
	localparam logic [7:0] LIXE_OP_STX = 8'h97;
	localparam logic [7:0] LIXE_OP_BIT = 8'h47;
	localparam logic [7:0] LIXE_OP_MLD = 8'hc3;
	localparam logic [7:0] LIXE_OP_MST = 8'hd3;
	localparam logic [7:0] LIXE_OP_MLDS = 8'he7;
	localparam logic [7:0] LIXE_OP_MSTS = 8'hf7;
	localparam logic [7:0] LIXE_OP_MLDL = 8'ha7;
	localparam logic [7:0] LIXE_OP_MSTL = 8'hb7;
	localparam logic [7:0] LIXE_OP_MLDD = 8'he2;
	localparam logic [7:0] LIXE_OP_MLDI = 8'he3;
	localparam logic [3:0] LIXE_DIR_PROG = 4'h0;
	localparam logic [3:0] LIXE_DIR_DATA = 4'h1;
	// ----------------------------------------------------------------
	// cycle counts
	// ----------------------------------------------------------------
	localparam logic [3:0] LIXE_CYC_SHORT = 4'h4;
	localparam logic [3:0] LIXE_CYC_LONG = 4'h6;
	localparam logic [3:0] LIXE_CYC_MEM = 4'ha;
	localparam logic [3:0] LIXE_CYC_MEMS = 4'hc;
	localparam logic [3:0] LIXE_CYC_MEML = 4'he;
	// ----------------------------------------------------------------
	// operation classes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LIXE_K_NONE = 3'b000,
		LIXE_K_BYTE = 3'b001,
		LIXE_K_BIT = 3'b010,
		LIXE_K_MLOAD = 3'b011,
		LIXE_K_MSTORE = 3'b100
	} lixe_kind_t;
	typedef enum logic [1:0] {
		LIXE_S_IDLE = 2'b00,
		LIXE_S_EXEC = 2'b01,
		LIXE_S_DONE = 2'b10
	} lixe_state_t;
endpackage
`default_nettype wire

//--- hw/lixe_decode.sv
`timescale 1ns/100ps
`default_nettype none
module lixe_decode (
	input wire logic [7:0] opc_i,
	output logic legal_o,
	output logic [3:0] cycles_o,
	output lixe_pkg::lixe_kind_t kind_o,
	output logic [1:0] offset_bytes_o,
	output logic step_o,
	output logic step_down_o
);
	// ----------------------------------------------------------------
	// opcode classification
	// ----------------------------------------------------------------
	always_comb begin
		legal_o = 1'b1;
		cycles_o = lixe_pkg::LIXE_CYC_LONG;
		kind_o = lixe_pkg::LIXE_K_BYTE;
		offset_bytes_o = 2'h0;
		step_o = 1'b0;
		step_down_o = 1'b0;
		case (opc_i)
		lixe_pkg::LIXE_OP_LDIR, lixe_pkg::LIXE_OP_STIR: begin
			cycles_o = lixe_pkg::LIXE_CYC_SHORT;
		end
		lixe_pkg::LIXE_OP_RR, lixe_pkg::LIXE_OP_RIR, lixe_pkg::LIXE_OP_RIM,
		lixe_pkg::LIXE_OP_IRIM, lixe_pkg::LIXE_OP_IRR,
		lixe_pkg::LIXE_OP_LDX, lixe_pkg::LIXE_OP_STX: begin
			cycles_o = lixe_pkg::LIXE_CYC_LONG;
		end
		lixe_pkg::LIXE_OP_BIT: begin
			kind_o = lixe_pkg::LIXE_K_BIT;
		end
		lixe_pkg::LIXE_OP_MLD, lixe_pkg::LIXE_OP_MST: begin
			cycles_o = lixe_pkg::LIXE_CYC_MEM;
			kind_o = opc_i[4] ? lixe_pkg::LIXE_K_MSTORE :
				lixe_pkg::LIXE_K_MLOAD;
		end
		lixe_pkg::LIXE_OP_MLDS, lixe_pkg::LIXE_OP_MSTS: begin
			cycles_o = lixe_pkg::LIXE_CYC_MEMS;
			kind_o = opc_i[4] ? lixe_pkg::LIXE_K_MSTORE :
				lixe_pkg::LIXE_K_MLOAD;
			offset_bytes_o = 2'h1;
		end
		lixe_pkg::LIXE_OP_MLDL, lixe_pkg::LIXE_OP_MSTL: begin
			cycles_o = lixe_pkg::LIXE_CYC_MEML;
			kind_o = opc_i[4] ? lixe_pkg::LIXE_K_MSTORE :
				lixe_pkg::LIXE_K_MLOAD;
			offset_bytes_o = 2'h2;
		end
		lixe_pkg::LIXE_OP_MLDD, lixe_pkg::LIXE_OP_MLDI: begin
			cycles_o = lixe_pkg::LIXE_CYC_MEM;
			kind_o = lixe_pkg::LIXE_K_MLOAD;
			step_o = 1'b1;
			step_down_o = ~opc_i[0];
		end
		default: begin
			case (opc_i[3:0])
			lixe_pkg::LIXE_NIB_IMM, lixe_pkg::LIXE_NIB_R2W,
			lixe_pkg::LIXE_NIB_W2R: begin
				cycles_o = lixe_pkg::LIXE_CYC_SHORT;
			end
			default: begin
				legal_o = 1'b0;
				kind_o = lixe_pkg::LIXE_K_NONE;
			end
			endcase
		end
		endcase
	end
endmodule
`default_nettype wire

//--- hw/lixe_core.sv

`timescale 1ns/100ps
`default_nettype none
module lixe_core #(
	parameter bit MASKED_ROM = 1'b1
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic start_i,
	input wire logic [7:0] opc_i,
	input wire logic [7:0] byte2_i,
	input wire logic [7:0] byte3_i,
	input wire logic [7:0] byte4_i,
	input wire logic [7:0] src_val_i,
	input wire logic [7:0] dst_val_i,
	input wire logic [15:0] pair_val_i,
	input wire logic [7:0] mem_rdata_i,
	output logic busy_o,
	output logic done_o,
	output logic illegal_o,
	output logic [3:0] cycles_o,
	output logic wr_en_o,
	output logic [7:0] wr_data_o,
	output logic pair_wr_o,
	output logic [15:0] pair_data_o,
	output logic mem_en_o,
	output logic mem_we_o,
	output logic mem_data_space_o,
	output logic [15:0] mem_addr_o,
	output logic [7:0] mem_wdata_o
);
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic dec_legal;
	logic [3:0] dec_cycles;
	lixe_pkg::lixe_kind_t dec_kind;
	logic [1:0] dec_off;
	logic dec_step;
	logic dec_down;
	lixe_decode u_dec (
		.opc_i(opc_i),
		.legal_o(dec_legal),
		.cycles_o(dec_cycles),
		.kind_o(dec_kind),
		.offset_bytes_o(dec_off),
		.step_o(dec_step),
		.step_down_o(dec_down)
	);
	// ----------------------------------------------------------------
	// operands
	// ----------------------------------------------------------------
	logic [3:0] pair_field;
	logic direct;
	logic [15:0] offset;
	logic [15:0] eff_addr;
	logic data_space;
	logic blocked;
	logic [7:0] bit_result;
	logic [2:0] bit_idx;
	always_comb begin
		pair_field = byte2_i[3:0];
		direct = (dec_off == 2'h2) && (pair_field == lixe_pkg::LIXE_DIR_PROG
			|| pair_field == lixe_pkg::LIXE_DIR_DATA);
		case (dec_off)
		2'h1: offset = {{8{byte3_i[7]}}, byte3_i};
		2'h2: offset = {byte4_i, byte3_i};
		default: offset = 16'h0000;
		endcase
		if (direct) begin
			eff_addr = {byte4_i, byte3_i};
		end else begin
			eff_addr = pair_val_i + offset;
		end
		data_space = pair_field[0];
		blocked = MASKED_ROM && (dec_kind == lixe_pkg::LIXE_K_MSTORE)
			&& !data_space;
		bit_idx = byte2_i[3:1];
		if (byte2_i[0]) begin
			bit_result = dst_val_i;
			bit_result[bit_idx] = src_val_i[0];
		end else begin
			bit_result = {dst_val_i[7:1], src_val_i[bit_idx]};
		end
	end
	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	lixe_pkg::lixe_state_t state_q;
	logic [3:0] cnt_q;
	lixe_pkg::lixe_kind_t kind_q;
	logic step_q;
	logic down_q;
	logic [15:0] addr_q;
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			state_q <= lixe_pkg::LIXE_S_IDLE;
			cnt_q <= 4'h0;
			kind_q <= lixe_pkg::LIXE_K_NONE;
			step_q <= 1'b0;
			down_q <= 1'b0;
			addr_q <= 16'h0000;
		end else begin
			case (state_q)
			lixe_pkg::LIXE_S_IDLE: begin
				if (start_i && dec_legal && !blocked) begin
					state_q <= lixe_pkg::LIXE_S_EXEC;
					cnt_q <= dec_cycles - 4'h1;
					kind_q <= dec_kind;
					step_q <= dec_step;
					down_q <= dec_down;
					addr_q <= pair_val_i;
				end
			end
			lixe_pkg::LIXE_S_EXEC: begin
				cnt_q <= cnt_q - 4'h1;
				if (cnt_q == 4'h2) begin
					state_q <= lixe_pkg::LIXE_S_DONE;
				end
			end
			lixe_pkg::LIXE_S_DONE: begin
				state_q <= lixe_pkg::LIXE_S_IDLE;
				cnt_q <= 4'h0;
			end
			default: begin
				state_q <= lixe_pkg::LIXE_S_IDLE;
			end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// results and bus outputs
	// ----------------------------------------------------------------
	logic go;
	assign go = (state_q == lixe_pkg::LIXE_S_IDLE) && start_i;
	logic accept;
	assign accept = go && dec_legal && !blocked;
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			busy_o <= 1'b0;
			illegal_o <= 1'b0;
			cycles_o <= 4'h0;
			wr_en_o <= 1'b0;
			wr_data_o <= 8'h00;
			mem_en_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_data_space_o <= 1'b0;
			mem_addr_o <= 16'h0000;
			mem_wdata_o <= 8'h00;
		end else begin
			illegal_o <= go && (!dec_legal || blocked);
			mem_en_o <= 1'b0;
			mem_we_o <= 1'b0;
			wr_en_o <= 1'b0;
			if (accept) begin
				busy_o <= 1'b1;
				cycles_o <= dec_cycles;
				case (dec_kind)
				lixe_pkg::LIXE_K_BYTE: begin
					wr_en_o <= 1'b1;
					wr_data_o <= src_val_i;
				end
				lixe_pkg::LIXE_K_BIT: begin
					wr_en_o <= 1'b1;
					wr_data_o <= bit_result;
				end
				lixe_pkg::LIXE_K_MLOAD, lixe_pkg::LIXE_K_MSTORE: begin
					mem_en_o <= 1'b1;
					mem_we_o <= (dec_kind == lixe_pkg::LIXE_K_MSTORE);
					mem_data_space_o <= data_space;
					mem_addr_o <= eff_addr;
					mem_wdata_o <= src_val_i;
				end
				default: begin
					wr_en_o <= 1'b0;
				end
				endcase
			end else if (state_q == lixe_pkg::LIXE_S_DONE) begin
				busy_o <= 1'b0;
				if (kind_q == lixe_pkg::LIXE_K_MLOAD) begin
					wr_en_o <= 1'b1;
					wr_data_o <= mem_rdata_i;
				end
			end
		end
	end
	// ----------------------------------------------------------------
	// completion and pair step
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			done_o <= 1'b0;
			pair_wr_o <= 1'b0;
			pair_data_o <= 16'h0000;
		end else begin
			done_o <= (state_q == lixe_pkg::LIXE_S_DONE);
			pair_wr_o <= (state_q == lixe_pkg::LIXE_S_DONE) && step_q;
			if (state_q == lixe_pkg::LIXE_S_DONE && step_q) begin
				pair_data_o <= down_q ? addr_q - 16'h0001
					: addr_q + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/lixe_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
module lixe_core_properties (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [7:0] opc_i,
	input wire logic [7:0] byte2_i,
	input wire logic [15:0] pair_val_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic illegal_o,
	input wire logic [3:0] cycles_o,
	input wire logic wr_en_o,
	input wire logic pair_wr_o,
	input wire logic [15:0] pair_data_o,
	input wire logic mem_en_o,
	input wire logic mem_we_o,
	input wire logic mem_data_space_o,
	input wire logic [15:0] mem_addr_o
);
	// ----
	// checks
	// ----
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	AST_QUIET: assert property (
		illegal_o |-> !(mem_en_o || wr_en_o || busy_o))
		else $error("refusal not quiet");
	AST_NO_PROG_STORE: assert property (
		mem_en_o && mem_we_o |-> mem_data_space_o)
		else $error("program store");
	AST_STEP: assert property (
		pair_wr_o |-> pair_data_o == (opc_i[0] ?
		pair_val_i + 16'h0001 : pair_val_i - 16'h0001))
		else $error("pair step");
	AST_SPACE: assert property (
		mem_en_o |-> mem_data_space_o == byte2_i[0])
		else $error("space");
	AST_PTR: assert property (
		mem_en_o && opc_i inside {8'hc3, 8'hd3, 8'he2, 8'he3}
		|-> mem_addr_o == pair_val_i) else $error("pointer");
	AST_BOUND: assert property ($rose(busy_o) |-> ##[1:14] done_o)
		else $error("no done");
	AST_NOMEM: assert property (
		mem_en_o |-> opc_i inside {8'hc3, 8'hd3, 8'he7, 8'hf7, 8'ha7,
		8'hb7, 8'he2, 8'he3}) else $error("byte op on bus");
	AST_DONE_CYC: assert property (
		done_o |-> cycles_o inside {4'h4, 4'h6, 4'ha, 4'hc, 4'he})
		else $error("cycles");
	cover property (pair_wr_o);
	cover property (illegal_o);
	cover property (mem_en_o && mem_we_o);
endmodule
`default_nettype wire

//--- verif/lixe_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module lixe_mem_model (
	input wire logic clk_sys_i,
	input wire logic mem_en_i,
	input wire logic mem_space_i,
	input wire logic [15:0] mem_addr_i,
	output logic [7:0] mem_rdata_o
);
	// ----
	// memory
	// ----
	logic [15:0] a_q = 16'h0000;
	logic s_q = 1'b0;
	always_ff @(posedge clk_sys_i) begin
		if (mem_en_i) begin
			a_q <= mem_addr_i;
			s_q <= mem_space_i;
		end
	end
	// each space answers with its own pattern
	assign mem_rdata_o = a_q[7:0] ^ a_q[15:8] ^ {s_q, 7'h35};
endmodule
`default_nettype wire

//--- verif/test_load_instruction_exec.sv
`timescale 1ns/100ps
`default_nettype none
module test_load_instruction_exec;
	// ----
	// stimulus and scoreboard
	// ----
	logic clk_sys_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0;
	logic [7:0] opc_i = 8'h00, byte2_i = 8'h00, byte3_i = 8'h00;
	logic [7:0] byte4_i = 8'h00, src_val_i = 8'h00, dst_val_i = 8'h00;
	logic [15:0] pair_val_i = 16'h0000, pair_data_o, mem_addr_o;
	logic [7:0] mem_rdata_i, wr_data_o, mem_wdata_o;
	logic busy_o, done_o, illegal_o, wr_en_o, pair_wr_o;
	logic mem_en_o, mem_we_o, mem_data_space_o;
	logic [3:0] cycles_o;
	logic [31:0] q[$];
	logic [7:0] ops[22] = '{8'h1c, 8'h28, 8'h39, 8'hc7, 8'hd7, 8'he4, 8'he5,
		8'he6, 8'hd6, 8'hf5, 8'h87, 8'h97, 8'h47, 8'hc3, 8'hd3, 8'he7, 8'hf7,
		8'ha7, 8'hb7, 8'he2, 8'he3, 8'h01};
	int miscompares = 0, n_compared = 0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	lixe_core dut (.clk_sys_i, .rstn_i, .start_i, .opc_i, .byte2_i, .byte3_i,
		.byte4_i, .src_val_i, .dst_val_i, .pair_val_i, .mem_rdata_i, .busy_o,
		.done_o, .illegal_o, .cycles_o, .wr_en_o, .wr_data_o, .pair_wr_o,
		.pair_data_o, .mem_en_o, .mem_we_o, .mem_data_space_o, .mem_addr_o,
		.mem_wdata_o);
	lixe_mem_model mem (.clk_sys_i, .mem_en_i(mem_en_o),
		.mem_space_i(mem_data_space_o), .mem_addr_i(mem_addr_o),
		.mem_rdata_o(mem_rdata_i));
	task automatic tally_and_finish();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got);
		logic [31:0] e;
		e = (q.size() > 0) ? q.pop_front() : 32'hffffffff;
		n_compared++;
		if (got !== e) begin
			miscompares++;
			$display("unexpected at %0t got %h want %h", $time, got, e);
		end
	endtask
	always @(posedge clk_sys_i) begin
		if (mem_en_o === 1'b1) chk({6'h04, mem_we_o,
			mem_data_space_o, mem_addr_o, mem_we_o ? mem_wdata_o : 8'h00});
		if (wr_en_o === 1'b1) chk({24'h200000, wr_data_o});
		if (pair_wr_o === 1'b1) chk({16'h3000, pair_data_o});
		if (done_o === 1'b1) chk({28'h4000000, cycles_o});
		if (illegal_o === 1'b1) chk(32'h50000000);
	end
	task automatic run(input logic [7:0] o, x2, input logic [15:0] pr);
		logic [7:0] r3, r4, rs, rd, v;
		logic [15:0] a;
		logic [3:0] n;
		logic m, st;
		int i;
		r3 = 8'($urandom);
		r4 = 8'($urandom);
		rs = 8'($urandom);
		rd = 8'($urandom);
		v = rs;
		a = pr;
		m = o inside {8'hc3, 8'hd3, 8'he7, 8'hf7, 8'ha7, 8'hb7, 8'he2, 8'he3};
		st = o inside {8'hd3, 8'hf7, 8'hb7};
		casez (o)
			8'h?c, 8'h?8, 8'h?9, 8'hc7, 8'hd7: n = 4'h4;
			8'he4, 8'he5, 8'he6, 8'hd6, 8'hf5, 8'h87, 8'h97: n = 4'h6;
			8'h47: begin
				n = 4'h6;
				v = rd;
				if (x2[0]) v[x2[3:1]] = rs[0];
				else v[0] = rs[x2[3:1]];
			end
			8'hc3, 8'hd3, 8'he2, 8'he3: n = 4'ha;
			8'he7, 8'hf7: begin
				n = 4'hc;
				a = pr + {{8{r3[7]}}, r3};
			end
			8'ha7, 8'hb7: begin
				n = 4'he;
				a = (x2[3:1] == 3'h0) ? {r4, r3} : pr + {r4, r3};
			end
			default: n = 4'h0;
		endcase
		if (n == 4'h0 || (st && !x2[0])) q.push_back(32'h50000000);
		else begin
			if (m) q.push_back({6'h04, st, x2[0], a, st ? rs : 8'h00});
			if (!st) q.push_back({24'h200000, m ?
				a[7:0] ^ a[15:8] ^ {x2[0], 7'h35} : v});
			if (o inside {8'he2, 8'he3}) q.push_back({16'h3000,
				o[0] ? pr + 16'h0001 : pr - 16'h0001});
			q.push_back({28'h4000000, n});
		end
		@(posedge clk_sys_i);
		opc_i <= o;
		byte2_i <= x2;
		byte3_i <= r3;
		byte4_i <= r4;
		src_val_i <= rs;
		dst_val_i <= rd;
		pair_val_i <= pr;
		start_i <= 1'b1;
		@(posedge clk_sys_i);
		start_i <= 1'b0;
		for (i = 0; i < 20 && done_o !== 1'b1 && illegal_o !== 1'b1; i++)
			@(posedge clk_sys_i);
		if (n != 4'h0 && !(st && !x2[0])) begin
			n_compared++;
			if (i != int'(n)) begin
				miscompares++;
				$display("unexpected at %0t took %h want %h", $time, i, n);
			end
		end
	endtask
	initial begin
		void'($urandom(69036));
		repeat (4) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		foreach (ops[k])
			for (int j = 0; j < 6; j++)
				run(ops[k], (j < 2) ? 8'(j) : 8'($urandom), (j == 2) ?
					16'h00ff : (j == 3) ? 16'h0100 : 16'($urandom));
		repeat (3) @(posedge clk_sys_i);
		if (q.size() != 0) begin
			miscompares++;
			$display("unexpected at %0t left %h want %h", $time, q.size(), 0);
		end
		tally_and_finish();
	end
	initial begin
		repeat (6000) @(posedge clk_sys_i);
		miscompares++;
		tally_and_finish();
	end
endmodule
bind lixe_core lixe_core_properties chk (.clk_sys_i, .rstn_i, .opc_i,
	.byte2_i, .pair_val_i, .busy_o, .done_o, .illegal_o, .cycles_o, .wr_en_o,
	.pair_wr_o, .pair_data_o, .mem_en_o, .mem_we_o, .mem_data_space_o,
	.mem_addr_o);
`default_nettype wire
